// *** rtl/fpec_consts.vh ***
/*
  constants for the flash program/erase sequencer: register map, fields, op codes, timing.
  assumes a 25 MHz system clock and an avalon-mm slave with word addressing.
*/
// Function
// - start bit launches selected self-timed operation
// - hardware clears start bit when done
// - stop-in-idle sleeps regulator, wake delay after
// - packing bit picks compressed or uncompressed rows
// - code 0011 erases one page
// - code 0010 programs a row from ram
// - code 0001 programs a double word
// - double word targets two-word aligned pair
// - other codes start no flash operation
// - main control bits cleared only by power-on
// - power-save ignored while operation runs
// - row program fetches ram, advances pointers
// - cpu stalls until operation finishes
`ifndef FPEC_CONSTS_VH
`define FPEC_CONSTS_VH

// ==========================================================
// register word addresses
`define FPEC_ADDR_CTRL 3'h0
`define FPEC_ADDR_KEY 3'h1
`define FPEC_ADDR_ADRL 3'h2
`define FPEC_ADDR_ADRH 3'h3
`define FPEC_ADDR_SRCL 3'h4
`define FPEC_ADDR_STAT 3'h5
`define FPEC_ADDR_MASK 3'h6

// ==========================================================
// control register fields
`define FPEC_BIT_START 15
`define FPEC_BIT_PROGRAM_ERASE_ENABLE 14
`define FPEC_BIT_SEQERR 13
`define FPEC_BIT_SIDL 12
`define FPEC_BIT_PACK 9
`define FPEC_BIT_UNDERRUN 8
`define FPEC_CTRL_RESET 16'h0000

// ==========================================================
// operation codes and key values
`define FPEC_OP_DWORD 4'h1
`define FPEC_OP_ROW 4'h2
`define FPEC_OP_ERASE 4'h3
`define FPEC_KEY_FIRST 8'h55
`define FPEC_KEY_SECOND 8'hAA

// ==========================================================
// timing, in microseconds, and row size
`define FPEC_CLK_MHZ 25
`define FPEC_T_ERASE_US 20000
`define FPEC_T_ROW_US 1500
`define FPEC_T_DWORD_US 50
`define FPEC_T_WAKE_US 10
`define FPEC_ROW_BYTES 192

// ==========================================================
// interrupt status bits
`define FPEC_IRQ_DONE 0
`define FPEC_IRQ_SEQERR 1
`define FPEC_IRQ_UNDERRUN 2

`endif

// *** rtl/fpec_timer.v ***
/*
  down-counter timing one self-timed phase; load starts it, done pulses at the end.
  assumes load is a one-cycle pulse on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module fpec_timer #(
  parameter WIDTH = 20
) (
  // clock and reset
  input wire clk_in,
  input wire srst_in,
  // control
  input wire load_in,
  input wire [WIDTH-1:0] count_in,
  // status
  output wire busy_out,
  output reg done_out
);
  reg [WIDTH-1:0] count;

  // ==========================================================
  // counter
  assign busy_out = (count != {WIDTH{1'b0}});
  always @(posedge clk_in) begin
    if (srst_in) begin
      count <= {WIDTH{1'b0}};
      done_out <= 1'b0;
    end else begin
      done_out <= (count == {{(WIDTH-1){1'b0}}, 1'b1});
      if (load_in) begin
        count <= count_in;
      end else if (busy_out) begin
        count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule
`default_nettype wire

// *** rtl/fpec_top.v ***
/*
  flash program/erase sequencer with avalon-mm register slave and interrupt.
  assumes a ram read port that answers ram_valid_in one or more cycles after ram_req_out,
  a flash write port that takes one word per ram word, and a separate power-on reset.
*/
// Local design decisions: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "fpec_consts.vh"
module fpec_top #(
  parameter T_ERASE_CYC = `FPEC_T_ERASE_US * `FPEC_CLK_MHZ,
  parameter T_ROW_CYC = `FPEC_T_ROW_US * `FPEC_CLK_MHZ,
  parameter T_DWORD_CYC = `FPEC_T_DWORD_US * `FPEC_CLK_MHZ,
  parameter T_WAKE_CYC = `FPEC_T_WAKE_US * `FPEC_CLK_MHZ,
  parameter TW = 20
) (
  // clock and resets
  input wire clk_in,
  input wire srst_in,
  input wire por_in,
  // avalon-mm slave
  input wire [2:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [15:0] avs_writedata_in,
  output reg [15:0] avs_readdata_out,
  output wire avs_waitrequest_out,
  // interrupt
  output wire irq_out,
  // power management
  input wire idle_in,
  input wire power_save_instruction_in,
  output wire power_save_grant_out,
  output wire regulator_standby_out,
  output wire flash_ready_out,
  output wire cpu_stall_out,
  // row data from ram
  output reg ram_req_out,
  output reg [15:0] ram_addr_out,
  output wire row_data_packing_out,
  input wire ram_valid_in,
  input wire ram_empty_in,
  input wire [15:0] ram_data_in,
  // flash array
  output reg flash_erase_out,
  output reg flash_prog_out,
  output reg [23:0] flash_addr_out,
  output reg [15:0] flash_data_out,
  output reg flash_wr_out
);
  localparam ST_IDLE = 3'h0;
  localparam ST_ERASE = 3'h1;
  localparam ST_DWORD = 3'h2;
  localparam ST_ROWFETCH = 3'h3;
  localparam ST_ROWWAIT = 3'h4;
  localparam ST_ROWPROG = 3'h5;
  localparam integer ROW_WORDS_N = `FPEC_ROW_BYTES / 2;
  localparam [7:0] ROW_WORDS = ROW_WORDS_N[7:0];
  localparam [TW-1:0] CYC_ERASE = T_ERASE_CYC[TW-1:0];
  localparam [TW-1:0] CYC_ROW = T_ROW_CYC[TW-1:0];
  localparam [TW-1:0] CYC_DWORD = T_DWORD_CYC[TW-1:0];
  localparam [TW-1:0] CYC_WAKE = T_WAKE_CYC[TW-1:0];

  reg start;
  reg program_erase_enable;
  reg seqerr;
  reg sidl;
  reg pack;
  reg underrun;
  reg [3:0] op_sel;
  reg [15:0] adr_lo;
  reg [7:0] adr_hi;
  reg [15:0] src_ptr;
  reg [1:0] key_state;
  reg [2:0] state;
  reg [7:0] word_cnt;
  reg [2:0] irq_stat;
  reg [2:0] irq_mask;
  reg idle_q;
  reg rd_ack;
  reg tmr_load;
  reg [TW-1:0] tmr_count;
  reg wake_load;
  wire tmr_busy;
  wire tmr_done;
  wire wake_busy;
  wire bus_wr;
  wire bus_rd;
  wire rd_take;
  wire start_req;
  wire unlocked;
  reg [2:0] ev;

  // ==========================================================
  // phase timers
  fpec_timer #(.WIDTH(TW)) u_op_timer (
    .clk_in(clk_in),
    .srst_in(por_in),
    .load_in(tmr_load),
    .count_in(tmr_count),
    .busy_out(tmr_busy),
    .done_out(tmr_done)
  );
  fpec_timer #(.WIDTH(TW)) u_wake_timer (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .load_in(wake_load),
    .count_in(CYC_WAKE),
    .busy_out(wake_busy),
    .done_out()
  );

  // ==========================================================
  // bus decode
  assign avs_waitrequest_out = avs_read_in && !rd_ack;
  assign bus_wr = avs_write_in;
  assign bus_rd = avs_read_in;
  assign rd_take = bus_rd && !rd_ack;
  assign unlocked = (key_state == 2'h2);
  assign start_req = bus_wr && (avs_address_in == `FPEC_ADDR_CTRL) &&
                     avs_writedata_in[`FPEC_BIT_START] && !start;

  // ==========================================================
  // power, stall and interrupt outputs
  assign row_data_packing_out = pack;
  assign cpu_stall_out = start;
  assign power_save_grant_out = power_save_instruction_in && !start;
  assign regulator_standby_out = sidl && idle_in && !start;
  assign flash_ready_out = !wake_busy && !wake_load && !(sidl && (idle_in || idle_q));
  assign irq_out = |(irq_stat & irq_mask);

  // ==========================================================
  // power-on-only control bits and operation sequencer
  always @(posedge clk_in) begin
    if (por_in) begin
      start <= 1'b0;
      program_erase_enable <= 1'b0;
      seqerr <= 1'b0;
      op_sel <= 4'h0;
      state <= ST_IDLE;
      word_cnt <= 8'h00;
      ram_req_out <= 1'b0;
      ram_addr_out <= 16'h0000;
      flash_erase_out <= 1'b0;
      flash_prog_out <= 1'b0;
      flash_addr_out <= 24'h000000;
      flash_data_out <= 16'h0000;
      flash_wr_out <= 1'b0;
      tmr_load <= 1'b0;
      tmr_count <= {TW{1'b0}};
      underrun <= 1'b0;
      src_ptr <= 16'h0000;
      adr_lo <= 16'h0000;
      adr_hi <= 8'h00;
      ev <= 3'h0;
    end else begin
      tmr_load <= 1'b0;
      flash_wr_out <= 1'b0;
      ev <= 3'h0;
      if (bus_wr && avs_address_in == `FPEC_ADDR_CTRL && !start) begin
        program_erase_enable <= avs_writedata_in[`FPEC_BIT_PROGRAM_ERASE_ENABLE];
        op_sel <= avs_writedata_in[3:0];
        if (!avs_writedata_in[`FPEC_BIT_SEQERR]) begin
          seqerr <= 1'b0;
        end
        if (!avs_writedata_in[`FPEC_BIT_UNDERRUN]) begin
          underrun <= 1'b0;
        end
      end
      if (bus_wr && avs_address_in == `FPEC_ADDR_ADRL && !start) begin
        adr_lo <= avs_writedata_in;
      end
      if (bus_wr && avs_address_in == `FPEC_ADDR_ADRH && !start) begin
        adr_hi <= avs_writedata_in[7:0];
      end
      if (bus_wr && avs_address_in == `FPEC_ADDR_SRCL && !start) begin
        src_ptr <= avs_writedata_in;
      end
      case (state)
        ST_IDLE: begin
          if (start_req) begin
            if (avs_writedata_in[`FPEC_BIT_PROGRAM_ERASE_ENABLE] && program_erase_enable && unlocked) begin
              start <= 1'b1;
              case (avs_writedata_in[3:0])
                `FPEC_OP_ERASE: begin
                  state <= ST_ERASE;
                  flash_erase_out <= 1'b1;
                  flash_addr_out <= {adr_hi, adr_lo};
                  tmr_load <= 1'b1;
                  tmr_count <= CYC_ERASE;
                end
                `FPEC_OP_ROW: begin
                  state <= ST_ROWFETCH;
                  flash_prog_out <= 1'b1;
                  flash_addr_out <= {adr_hi, adr_lo};
                  ram_addr_out <= src_ptr;
                  word_cnt <= ROW_WORDS;
                end
                `FPEC_OP_DWORD: begin
                  state <= ST_DWORD;
                  flash_prog_out <= 1'b1;
                  flash_addr_out <= {adr_hi, adr_lo[15:2], 2'b00};
                  flash_wr_out <= 1'b1;
                  tmr_load <= 1'b1;
                  tmr_count <= CYC_DWORD;
                end
                default: begin
                  start <= 1'b0;
                  ev[`FPEC_IRQ_DONE] <= 1'b1;
                end
              endcase
            end else begin
              seqerr <= 1'b1;
              ev[`FPEC_IRQ_SEQERR] <= 1'b1;
            end
          end
        end
        ST_ERASE, ST_DWORD: begin
          if (flash_prog_out && flash_wr_out && !flash_addr_out[1]) begin
            flash_addr_out <= flash_addr_out + 24'h000002;
            flash_wr_out <= 1'b1;
          end
          if (tmr_done) begin
            start <= 1'b0;
            flash_erase_out <= 1'b0;
            flash_prog_out <= 1'b0;
            state <= ST_IDLE;
            ev[`FPEC_IRQ_DONE] <= 1'b1;
          end
        end
        ST_ROWFETCH: begin
          if (flash_wr_out) begin
            flash_addr_out <= flash_addr_out + 24'h000002;
          end
          if (ram_empty_in) begin
            underrun <= 1'b1;
            seqerr <= 1'b1;
            start <= 1'b0;
            flash_prog_out <= 1'b0;
            state <= ST_IDLE;
            ev[`FPEC_IRQ_UNDERRUN] <= 1'b1;
          end else begin
            ram_req_out <= 1'b1;
            state <= ST_ROWWAIT;
          end
        end
        ST_ROWWAIT: begin
          if (ram_valid_in) begin
            ram_req_out <= 1'b0;
            flash_data_out <= ram_data_in;
            flash_wr_out <= 1'b1;
            ram_addr_out <= ram_addr_out + 16'h0002;
            src_ptr <= src_ptr + 16'h0002;
            word_cnt <= word_cnt - 8'h01;
            if (word_cnt == 8'h01) begin
              state <= ST_ROWPROG;
              tmr_load <= 1'b1;
              tmr_count <= CYC_ROW;
            end else begin
              state <= ST_ROWFETCH;
            end
          end
        end
        ST_ROWPROG: begin
          if (flash_wr_out) begin
            flash_addr_out <= flash_addr_out + 24'h000002;
          end
          if (tmr_done) begin
            start <= 1'b0;
            flash_prog_out <= 1'b0;
            state <= ST_IDLE;
            ev[`FPEC_IRQ_DONE] <= 1'b1;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // key sequence, idle options, interrupt registers (system reset)
  always @(posedge clk_in) begin
    if (srst_in) begin
      key_state <= 2'h0;
      sidl <= 1'b0;
      pack <= 1'b0;
      irq_stat <= 3'h0;
      irq_mask <= 3'h0;
      idle_q <= 1'b0;
      wake_load <= 1'b0;
      rd_ack <= 1'b0;
    end else begin
      rd_ack <= rd_take;
      idle_q <= idle_in;
      wake_load <= idle_q && !idle_in && sidl;
      if (bus_wr) begin
        if (avs_address_in == `FPEC_ADDR_KEY) begin
          if (avs_writedata_in[7:0] == `FPEC_KEY_FIRST) begin
            key_state <= 2'h1;
          end else if (avs_writedata_in[7:0] == `FPEC_KEY_SECOND && key_state == 2'h1) begin
            key_state <= 2'h2;
          end else begin
            key_state <= 2'h0;
          end
        end else begin
          key_state <= 2'h0;
        end
        if (avs_address_in == `FPEC_ADDR_CTRL) begin
          sidl <= avs_writedata_in[`FPEC_BIT_SIDL];
          if (!start) begin
            pack <= avs_writedata_in[`FPEC_BIT_PACK];
          end
        end
        if (avs_address_in == `FPEC_ADDR_MASK) begin
          irq_mask <= avs_writedata_in[2:0];
        end
      end
      if (rd_take && avs_address_in == `FPEC_ADDR_STAT) begin
        irq_stat <= ev;
      end else begin
        irq_stat <= irq_stat | ev;
      end
    end
  end

  // ==========================================================
  // read data
  always @(posedge clk_in) begin
    if (srst_in) begin
      avs_readdata_out <= 16'h0000;
    end else if (rd_take) begin
      case (avs_address_in)
        `FPEC_ADDR_CTRL: avs_readdata_out <= {start, program_erase_enable, seqerr, sidl, 2'b00, pack, underrun, 4'h0, op_sel};
        `FPEC_ADDR_ADRL: avs_readdata_out <= adr_lo;
        `FPEC_ADDR_ADRH: avs_readdata_out <= {8'h00, adr_hi};
        `FPEC_ADDR_SRCL: avs_readdata_out <= src_ptr;
        `FPEC_ADDR_STAT: avs_readdata_out <= {13'h0000, irq_stat};
        `FPEC_ADDR_MASK: avs_readdata_out <= {13'h0000, irq_mask};
        default: avs_readdata_out <= 16'h0000;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** bench/fpec_top_sva.sv ***
/*
  port checker for the flash program/erase sequencer.
  assumes a bind from the bench top and short sim timings.
*/
`timescale 1ns/1ps
`default_nettype none
module fpec_top_sva (
  // clock and resets
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic por_in,
  // bus and power
  input wire logic avs_read_in,
  input wire logic avs_waitrequest_out,
  input wire logic idle_in,
  input wire logic power_save_instruction_in,
  input wire logic power_save_grant_out,
  input wire logic regulator_standby_out,
  input wire logic flash_ready_out,
  input wire logic cpu_stall_out,
  // ram and flash
  input wire logic ram_req_out,
  input wire logic flash_erase_out,
  input wire logic flash_prog_out,
  input wire logic flash_wr_out
);
  // ==========================================================
  // properties
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in || por_in);
  sequence s_op_ends;
    ##[1:1000] !cpu_stall_out;
  endsequence
  sequence s_wake;
    !flash_ready_out ##1 !flash_ready_out;
  endsequence
  a_wait_read: assert property (avs_waitrequest_out |-> avs_read_in) else $error("waitrequest outside read");
  a_read_answer: assert property (avs_read_in && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("read not answered");
  a_op_stalls: assert property (flash_erase_out || flash_prog_out |-> cpu_stall_out)
    else $error("flash op without stall");
  a_psave_gate: assert property (power_save_grant_out == (power_save_instruction_in && !cpu_stall_out))
    else $error("power save grant wrong");
  a_standby_idle: assert property (regulator_standby_out |-> idle_in && !flash_ready_out)
    else $error("standby outside idle");
  a_wake_delay: assert property ($fell(idle_in) && $past(regulator_standby_out) |-> s_wake)
    else $error("flash ready too early");
  a_op_ends: assert property ($rose(cpu_stall_out) |-> s_op_ends)
    else $error("start never cleared");
  a_erase_holds: assert property ($rose(flash_erase_out) |-> flash_erase_out [*8])
    else $error("erase too short");
  a_ram_in_op: assert property (ram_req_out |-> cpu_stall_out)
    else $error("ram fetch outside op");
  a_wr_in_prog: assert property (flash_wr_out |-> flash_prog_out && !flash_erase_out)
    else $error("flash write outside program");
endmodule
`default_nettype wire

// *** bench/flash_program_erase_control_test.sv ***
/*
  self-checking bench for the flash program/erase sequencer.
  assumes fpec_top and its checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module flash_program_erase_control_test;
  reg clk_in = 1'b0, srst_in = 1'b1, por_in = 1'b1;
  reg [2:0] avs_address_in = 3'h0;
  reg avs_read_in = 1'b0, avs_write_in = 1'b0, idle_in = 1'b0, power_save_instruction_in = 1'b0;
  reg ram_valid_in = 1'b0, ram_empty_in = 1'b0, seen_erase = 1'b0, seen_prog = 1'b0, seen_pack = 1'b0;
  reg mon_clr = 1'b0;
  reg [15:0] avs_writedata_in = 16'h0000, ram_data_in = 16'h0000, rdata;
  reg [23:0] first_addr = 24'h000000;
  integer err_count = 0, comparisons = 0, wr_cnt = 0;
  wire [15:0] avs_readdata_out, ram_addr_out, flash_data_out;
  wire [23:0] flash_addr_out;
  wire avs_waitrequest_out, irq_out, power_save_grant_out, regulator_standby_out, flash_ready_out;
  wire cpu_stall_out, ram_req_out, row_data_packing_out, flash_erase_out, flash_prog_out, flash_wr_out;
  fpec_top #(.T_ERASE_CYC(20), .T_ROW_CYC(10), .T_DWORD_CYC(5), .T_WAKE_CYC(4), .TW(20)) i_dut (
    .clk_in(clk_in), .srst_in(srst_in), .por_in(por_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out), .irq_out(irq_out),
    .idle_in(idle_in), .power_save_instruction_in(power_save_instruction_in),
    .power_save_grant_out(power_save_grant_out), .regulator_standby_out(regulator_standby_out),
    .flash_ready_out(flash_ready_out), .cpu_stall_out(cpu_stall_out), .ram_req_out(ram_req_out),
    .ram_addr_out(ram_addr_out), .row_data_packing_out(row_data_packing_out), .ram_valid_in(ram_valid_in),
    .ram_empty_in(ram_empty_in), .ram_data_in(ram_data_in), .flash_erase_out(flash_erase_out),
    .flash_prog_out(flash_prog_out), .flash_addr_out(flash_addr_out), .flash_data_out(flash_data_out),
    .flash_wr_out(flash_wr_out));
  // ==========================================================
  // clock, ram responder and monitors
  initial forever #20 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    ram_valid_in <= ram_req_out && !ram_valid_in && !ram_empty_in;
    ram_data_in <= ~ram_addr_out;
    if (mon_clr) begin
      wr_cnt <= 0;
      seen_erase <= 1'b0;
      seen_prog <= 1'b0;
      seen_pack <= 1'b0;
    end else begin
      if (flash_wr_out === 1'b1) begin
        if (wr_cnt == 0) first_addr <= flash_addr_out;
        wr_cnt <= wr_cnt + 1;
      end
      if (flash_erase_out === 1'b1) seen_erase <= 1'b1;
      if (flash_prog_out === 1'b1) seen_prog <= 1'b1;
      if (flash_prog_out === 1'b1 && row_data_packing_out === 1'b1) seen_pack <= 1'b1;
    end
  end
  task clr_mon;
    begin
      mon_clr <= 1'b1;
      @(posedge clk_in);
      mon_clr <= 1'b0;
    end
  endtask
  // ==========================================================
  // bus tasks
  task bus(input wr, input [2:0] a, input [15:0] d);
    begin
      avs_address_in <= a;
      avs_writedata_in <= d;
      avs_write_in <= wr;
      avs_read_in <= !wr;
      @(posedge clk_in);
      while (avs_waitrequest_out !== 1'b0) @(posedge clk_in);
      rdata = avs_readdata_out;
      avs_write_in <= 1'b0;
      avs_read_in <= 1'b0;
      @(posedge clk_in);
    end
  endtask
  task unlock(input [15:0] c0, input [15:0] c1);
    begin
      bus(1, 3'h0, c0);
      bus(1, 3'h1, 16'h0055);
      bus(1, 3'h1, 16'h00AA);
      bus(1, 3'h0, c1);
    end
  endtask
  task wait_done;
    integer n;
    begin
      n = 0;
      while (cpu_stall_out === 1'b1 && n < 2000) begin
        @(posedge clk_in);
        n = n + 1;
      end
      `CHK(cpu_stall_out, 1'b0)
      @(posedge clk_in);
    end
  endtask
  // ==========================================================
  // scenarios
  task t_regs;
    begin
      bus(0, 3'h0, 16'h0000); `CHK(rdata, 16'h0000)
      bus(0, 3'h1, 16'h0000); `CHK(rdata, 16'h0000)
      bus(1, 3'h7, 16'hFFFF);
      bus(0, 3'h7, 16'h0000); `CHK(rdata, 16'h0000)
      `CHK(irq_out, 1'b0)
    end
  endtask
  task t_op(input [3:0] op, input pk, input e_er, input e_pr, input integer e_wr);
    reg [15:0] c;
    begin
      c = {6'h00, pk, 5'h00, op};
      clr_mon;
      power_save_instruction_in <= 1'b1;
      bus(1, 3'h6, 16'h0007);
      bus(1, 3'h2, 16'h0007);
      unlock(c | 16'h4000, c | 16'hC000);
      if (e_er || e_pr) `CHK(cpu_stall_out, 1'b1)
      if (e_er || e_pr) `CHK(power_save_grant_out, 1'b0)
      wait_done;
      `CHK(seen_erase, e_er)
      `CHK(seen_prog, e_pr)
      `CHK(wr_cnt, e_wr)
      `CHK(seen_pack, pk)
      `CHK(power_save_grant_out, 1'b1)
      power_save_instruction_in <= 1'b0;
      `CHK(irq_out, 1'b1)
      bus(0, 3'h5, 16'h0000); `CHK(rdata[0], 1'b1)
      `CHK(irq_out, 1'b0)
      bus(0, 3'h0, 16'h0000); `CHK(rdata[15], 1'b0)
    end
  endtask
  task t_seqerr;
    begin
      bus(1, 3'h6, 16'h0000);
      unlock(16'h0003, 16'h8003);
      `CHK(cpu_stall_out, 1'b0)
      `CHK(irq_out, 1'b0)
      bus(1, 3'h6, 16'h0007); `CHK(irq_out, 1'b1)
      bus(0, 3'h5, 16'h0000); `CHK(rdata[1], 1'b1)
      `CHK(irq_out, 1'b0)
      bus(0, 3'h0, 16'h0000); `CHK(rdata[13], 1'b1)
      bus(1, 3'h0, 16'h0000);
      bus(0, 3'h0, 16'h0000); `CHK(rdata, 16'h0000)
    end
  endtask
  task t_underrun;
    begin
      ram_empty_in <= 1'b1;
      clr_mon;
      unlock(16'h4002, 16'hC002);
      wait_done;
      `CHK(wr_cnt, 0)
      bus(0, 3'h0, 16'h0000); `CHK(rdata[8], 1'b1)
      bus(0, 3'h5, 16'h0000); `CHK(rdata[2], 1'b1)
      ram_empty_in <= 1'b0;
      bus(1, 3'h0, 16'h0000);
    end
  endtask
  task t_idle;
    begin
      bus(1, 3'h0, 16'h1000);
      idle_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      `CHK(regulator_standby_out, 1'b1)
      `CHK(flash_ready_out, 1'b0)
      idle_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      `CHK(flash_ready_out, 1'b0)
      repeat (8) @(posedge clk_in);
      `CHK(flash_ready_out, 1'b1)
      bus(1, 3'h0, 16'h0000);
    end
  endtask
  task t_por;
    begin
      bus(1, 3'h0, 16'h5202);
      srst_in <= 1'b1;
      @(posedge clk_in);
      srst_in <= 1'b0;
      bus(0, 3'h0, 16'h0000); `CHK(rdata, 16'h4002)
      por_in <= 1'b1;
      @(posedge clk_in);
      por_in <= 1'b0;
      bus(0, 3'h0, 16'h0000); `CHK(rdata, 16'h0000)
    end
  endtask
  // ==========================================================
  // sequence, watchdog and verdict
  task print_verdict;
    begin
      $display("errors %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  initial begin
    repeat (3) @(posedge clk_in);
    srst_in <= 1'b0;
    por_in <= 1'b0;
    t_regs;
    t_op(4'h3, 1'b0, 1'b1, 1'b0, 0);
    t_op(4'h2, 1'b1, 1'b0, 1'b1, 96);
    t_op(4'h1, 1'b0, 1'b0, 1'b1, 2);
    `CHK(first_addr[1:0], 2'b00)
    t_op(4'h0, 1'b0, 1'b0, 1'b0, 0);
    t_op(4'hF, 1'b0, 1'b0, 1'b0, 0);
    t_seqerr;
    t_underrun;
    t_idle;
    t_por;
    print_verdict;
  end
  initial begin
    #2000000;
    err_count = err_count + 1;
    print_verdict;
  end
endmodule
bind fpec_top fpec_top_sva i_chk (.clk_in(clk_in), .srst_in(srst_in), .por_in(por_in),
  .avs_read_in(avs_read_in), .avs_waitrequest_out(avs_waitrequest_out), .idle_in(idle_in),
  .power_save_instruction_in(power_save_instruction_in), .power_save_grant_out(power_save_grant_out),
  .regulator_standby_out(regulator_standby_out), .flash_ready_out(flash_ready_out),
  .cpu_stall_out(cpu_stall_out), .ram_req_out(ram_req_out), .flash_erase_out(flash_erase_out),
  .flash_prog_out(flash_prog_out), .flash_wr_out(flash_wr_out));
`default_nettype wire
